//--- dv/acp_main_model.sv
// main processor side: doorbell, nmi and write-done sources
`timescale 1ns/1ps
`default_nettype none
module acp_main_model (
   // clock
   input wire logic clk_i,
   // lines to and from the block
   input wire logic main_irq_i,
   output logic doorbell_o,
   output logic nmi_o,
   output logic ext_done_o
);
   initial begin
      doorbell_o = 1'b0;
      nmi_o = 1'b0;
      ext_done_o = 1'b0;
   end
   // one-cycle positive pulse on the doorbell line
   task automatic ring();
      @(posedge clk_i);
      doorbell_o <= 1'b1;
      @(posedge clk_i);
      doorbell_o <= 1'b0;
   endtask : ring
   // one-cycle pulse marking an external write as finished
   task automatic write_done();
      @(posedge clk_i);
      ext_done_o <= 1'b1;
      @(posedge clk_i);
      ext_done_o <= 1'b0;
   endtask : write_done
   task automatic set_nmi(input logic v);
      @(posedge clk_i);
      nmi_o <= v;
   endtask : set_nmi
endmodule : acp_main_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the audio core peripherals
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import acp_pkg::*;
   logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [15:0] awaddr, araddr, vector;
   logic [31:0] wdata, rdata, prod;
   logic [1:0] bresp, rresp, rd_r;
   logic db, nmi, ext_done, main_irq, irq_req, nmi_req, sleep;
   logic [11:0] dac_l, dac_r;
   logic [7:0] pa_o, pa_oe, pa_pull, pb_oe, rd_v;
   logic [7:0] pa_pu, pb_o, pb_pe, pb_pu, pb_in;
   logic [13:0] t_base [2];
   logic [15:0] t_vec [2];
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int n;
   acp_top i_dut (.CLK_I(clk), .ARST_N_I(arst_n), .AWADDR_I(awaddr),
      .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
      .WSTRB_I(4'hf), .WVALID_I(wvalid), .WREADY_O(wready),
      .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
      .RREADY_I(rready), .DOORBELL_I(db), .NMI_I(nmi),
      .EXT_WRITE_DONE_I(ext_done), .MAIN_IRQ_O(main_irq),
      .IRQ_REQ_O(irq_req), .NMI_REQ_O(nmi_req), .VECTOR_O(vector),
      .SLEEP_O(sleep), .DAC_L_O(dac_l), .DAC_R_O(dac_r), .PA_I(8'h00),
      .PA_O(pa_o), .PA_OE_O(pa_oe), .PA_PULL_EN_O(pa_pull),
      .PA_PULL_UP_O(pa_pu), .PB_I(pb_in), .PB_O(pb_o), .PB_OE_O(pb_oe),
      .PB_PULL_EN_O(pb_pe), .PB_PULL_UP_O(pb_pu));
   acp_main_model i_main (.clk_i(clk), .main_irq_i(main_irq),
      .doorbell_o(db), .nmi_o(nmi), .ext_done_o(ext_done));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors = num_errors + 1;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [13:0] ix, input logic [7:0] d);
      @(posedge clk);
      awaddr <= {ix, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [13:0] ix);
      @(posedge clk);
      araddr <= {ix, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_v = rdata[7:0];
      rd_r = rresp;
      rready <= 1'b0;
   endtask : rd
   // collect the left word of one serial frame; lag skips the i2s delay
   task automatic sa_left(input int lag);
      logic [15:0] w;
      w = 16'h0;
      while (pb_o[PB_WSEL] !== 1'b1) @(posedge clk);
      while (pb_o[PB_WSEL] !== 1'b0) @(posedge clk);
      for (int k = 0; k < 16 + lag; k++) begin
         @(posedge pb_o[PB_BCLK]);
         w = {w[14:0], pb_o[PB_SDAT]};
      end
      chk(w, 16'habcd);
   endtask : sa_left
   initial begin
      arst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 16'h0;
      araddr = 16'h0;
      wdata = 32'h0;
      pb_in = 8'hff;
      t_base = '{IX_TA_LO, IX_TB_LO};
      t_vec = '{VEC_TA, VEC_TB};
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(vector, VEC_RST);
      wr(IX_L_LO, 8'hcd);
      wr(IX_L_HI, 8'hab);
      repeat (2) @(posedge clk);
      chk(dac_l, 12'habc);
      wr(IX_OP0, 8'h34);
      wr(IX_OP1, 8'h12);
      wr(IX_MC_LO, 8'h02);
      wr(IX_MC_HI, 8'h00);
      repeat (20) @(posedge clk);
      prod = 32'h2468;
      for (int i = 0; i < 4; i++) begin
         rd(IX_OP0 + 14'(i));
         chk(rd_v, prod[8*i+:8]);
      end
      wr(IX_OP0, 8'h64);
      for (int i = 1; i < 4; i++) wr(IX_OP0 + 14'(i), 8'h00);
      wr(IX_DV_LO, 8'h07);
      wr(IX_DV_HI, 8'h00);
      repeat (36) @(posedge clk);
      rd(IX_OP0);
      chk(rd_v, 8'h0e);
      rd(IX_MC_LO);
      chk(rd_v, 8'h02);
      for (int i = 0; i < 2; i++) begin
         wr(t_base[i], 8'hf0);
         wr(t_base[i] + 14'h1, 8'hff);
         wr(t_base[i] + 14'h2, 8'h03);
         n = 0;
         while (irq_req !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
         end
         chk(vector, t_vec[i]);
         wr(t_base[i] + 14'h2, 8'h02);
         chk(irq_req, 1'b1);
         wr(t_base[i] + 14'h3, 8'h00);
         repeat (2) @(posedge clk);
         chk(irq_req, 1'b0);
      end
      wr(IX_ISC, 8'h08);
      repeat (2) @(posedge clk);
      chk(sleep, 1'b1);
      i_main.ring();
      repeat (3) @(posedge clk);
      chk(sleep, 1'b0);
      chk(vector, VEC_DB);
      rd(IX_ISC);
      chk(rd_v[7], 1'b1);
      repeat (2) @(posedge clk);
      chk(irq_req, 1'b0);
      wr(IX_ISC, 8'h12);
      i_main.set_nmi(1'b1);
      repeat (3) @(posedge clk);
      chk(main_irq, 1'b1);
      chk(vector, VEC_NMI);
      wr(IX_ISC, 8'h00);
      repeat (2) @(posedge clk);
      chk({main_irq, nmi_req}, 2'b00);
      wr(IX_PA_DIR, 8'h0f);
      wr(IX_PA_ATT, 8'hf0);
      wr(IX_PA_DAT, 8'h35);
      wr(IX_SA, 8'h01);
      repeat (2) @(posedge clk);
      chk({pa_oe, pa_pull, pa_pu[7:4], pa_o[3:0]}, 24'h0f_f035);
      chk(pb_oe[6:4], 3'h7);
      sa_left(0);
      wr(IX_SA, 8'h03);
      sa_left(1);
      wr(IX_PB_ATT, 8'h80);
      wr(IX_PB_DAT, 8'h80);
      wr(IX_ISC, 8'h01);
      pb_in <= 8'h7f;
      repeat (5) @(posedge clk);
      chk({pb_pe, pb_pu, vector}, {16'h8080, VEC_EXT});
      rd(IX_PB_DAT);
      chk(rd_v, 8'h7f);
      wr(IX_ISC, 8'h05);
      chk(irq_req, 1'b0);
      i_main.write_done();
      repeat (2) @(posedge clk);
      chk({irq_req, vector}, {1'b1, VEC_EXT});
      rd(14'h3000);
      chk(rd_r, RESP_ERR);
      stop_test();
   end
endmodule : testbench
`default_nettype wire

//--- hw/acp_pkg.sv
// constants for the audio core peripheral block
// Summary of operation
// - writing timer A reload high byte copies full reload into counter
// - timer interrupt period is 65536 minus reload in core clocks
// - timer A control bit 0 run enable, bit 1 interrupt enable
// - any write to timer A clear address clears its flag
// - timer B mirrors timer A at its own addresses
// - converter outputs use sample bits 15 to 4 only
// - serial audio drives 16-bit stereo on port B pins 4-6 when enabled
// - serial audio control bit 1 selects MSB-justified or I2S framing
// - vectors: NMI 0ffa, external 0ffe, timer A 0ff8, B 0ff6, doorbell 0ff4
// - masked interrupts still set their flags but are not requested; doorbell has no mask
// - control bit 4 drives the main processor interrupt line
// - rising doorbell pulse from main processor sets doorbell flag
// - reading interrupt control clears incoming doorbell flag
// - external source is pin B7 falling edge or external write done
// - sleep bit halts core; unmasked interrupts wake it
// - multiply 16x16 into results 0-3, starts on high byte, 16 cycles
// - multiply changes multiplicand bytes, keeps operand bytes 0-1
// - divide 32 by 16, starts on divisor high byte, 32 cycles
// - remainder in results 4-5 directly when quotient lsb is 0
// - divide changes operand bytes 0-3, keeps divisor bytes
// - each pin has direction, attribute and data bit
package acp_pkg;
   localparam int AXI_AW = 16;
   localparam logic [13:0] IX_TA_LO = 14'h2100;
   localparam logic [13:0] IX_TA_HI = 14'h2101;
   localparam logic [13:0] IX_TA_CTL = 14'h2102;
   localparam logic [13:0] IX_TA_CLR = 14'h2103;
   localparam logic [13:0] IX_TB_LO = 14'h2110;
   localparam logic [13:0] IX_TB_HI = 14'h2111;
   localparam logic [13:0] IX_TB_CTL = 14'h2112;
   localparam logic [13:0] IX_TB_CLR = 14'h2113;
   localparam logic [13:0] IX_L_LO = 14'h2118;
   localparam logic [13:0] IX_L_HI = 14'h2119;
   localparam logic [13:0] IX_R_LO = 14'h211a;
   localparam logic [13:0] IX_R_HI = 14'h211b;
   localparam logic [13:0] IX_ISC = 14'h211c;
   localparam logic [13:0] IX_SA = 14'h211d;
   localparam logic [13:0] IX_OP0 = 14'h2130;
   localparam logic [13:0] IX_OP1 = 14'h2131;
   localparam logic [13:0] IX_OP2 = 14'h2132;
   localparam logic [13:0] IX_OP3 = 14'h2133;
   localparam logic [13:0] IX_MC_LO = 14'h2134;
   localparam logic [13:0] IX_MC_HI = 14'h2135;
   localparam logic [13:0] IX_DV_LO = 14'h2136;
   localparam logic [13:0] IX_DV_HI = 14'h2137;
   localparam logic [13:0] IX_PA_DAT = 14'h2140;
   localparam logic [13:0] IX_PA_DIR = 14'h2141;
   localparam logic [13:0] IX_PA_ATT = 14'h2142;
   localparam logic [13:0] IX_PB_DAT = 14'h2144;
   localparam logic [13:0] IX_PB_DIR = 14'h2145;
   localparam logic [13:0] IX_PB_ATT = 14'h2146;
   localparam int CTL_RUN = 0;
   localparam int CTL_IE = 1;
   localparam int ISC_EXT_EN = 0;
   localparam int ISC_NMI_EN = 1;
   localparam int ISC_EXT_SEL = 2;
   localparam int ISC_SLEEP = 3;
   localparam int ISC_DB_OUT = 4;
   localparam int SA_EN = 0;
   localparam int SA_FMT = 1;
   localparam int PB_BCLK = 4;
   localparam int PB_SDAT = 5;
   localparam int PB_WSEL = 6;
   localparam int PB_EXT = 7;
   localparam logic [15:0] VEC_NMI = 16'h0ffa;
   localparam logic [15:0] VEC_EXT = 16'h0ffe;
   localparam logic [15:0] VEC_TA = 16'h0ff8;
   localparam logic [15:0] VEC_TB = 16'h0ff6;
   localparam logic [15:0] VEC_DB = 16'h0ff4;
   localparam logic [15:0] VEC_RST = 16'h0ffc;
   localparam logic [15:0] TMR_TOP = 16'hffff;
   localparam logic [5:0] MUL_CYC = 6'h10;
   localparam logic [5:0] DIV_CYC = 6'h20;
   localparam int CLK_NS = 10;
   localparam int SA_BCLK_NS = 80;
   localparam int SA_HALF_CYC = SA_BCLK_NS / 2 / CLK_NS;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   typedef enum logic [2:0] {
      AR_IDLE = 3'h1,
      AR_MUL = 3'h2,
      AR_DIV = 3'h4
   } arith_t;
endpackage : acp_pkg

//--- hw/acp_top.sv
// audio core peripherals: timers, interrupts, arithmetic, audio, pins
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acp_top (
   // clock and reset
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   // axi4-lite slave
   input wire logic [acp_pkg::AXI_AW-1:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [acp_pkg::AXI_AW-1:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // main processor side
   input wire logic DOORBELL_I,
   input wire logic NMI_I,
   input wire logic EXT_WRITE_DONE_I,
   output logic MAIN_IRQ_O,
   // core side
   output logic IRQ_REQ_O,
   output logic NMI_REQ_O,
   output logic [15:0] VECTOR_O,
   output logic SLEEP_O,
   // converter
   output logic [11:0] DAC_L_O,
   output logic [11:0] DAC_R_O,
   // port a pins
   input wire logic [7:0] PA_I,
   output logic [7:0] PA_O,
   output logic [7:0] PA_OE_O,
   output logic [7:0] PA_PULL_EN_O,
   output logic [7:0] PA_PULL_UP_O,
   // port b pins
   input wire logic [7:0] PB_I,
   output logic [7:0] PB_O,
   output logic [7:0] PB_OE_O,
   output logic [7:0] PB_PULL_EN_O,
   output logic [7:0] PB_PULL_UP_O
);
   import acp_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic [13:0] aw_ix;
      logic w_got;
      logic [7:0] w_b;
      logic w_en;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] ta_rel;
      logic [15:0] ta_cnt;
      logic [1:0] ta_ctl;
      logic ta_flag;
      logic [15:0] tb_rel;
      logic [15:0] tb_cnt;
      logic [1:0] tb_ctl;
      logic tb_flag;
      logic [15:0] smp_l;
      logic [15:0] smp_r;
      logic [4:0] isc;
      logic [1:0] sa_ctl;
      logic db_flag;
      logic db_prev;
      logic ext_flag;
      logic b7_prev;
      logic [31:0] opnd;
      logic [15:0] mc;
      logic [15:0] dv;
      logic [47:0] res;
      arith_t ar;
      logic [5:0] ar_cnt;
      logic [16:0] rem;
      logic [7:0] pa_dat;
      logic [7:0] pa_dir;
      logic [7:0] pa_att;
      logic [7:0] pb_dat;
      logic [7:0] pb_dir;
      logic [7:0] pb_att;
      logic [7:0] pa_s1;
      logic [7:0] pa_s2;
      logic [7:0] pb_s1;
      logic [7:0] pb_s2;
      logic [2:0] sa_div;
      logic sa_bclk;
      logic [4:0] sa_cnt;
      logic [7:0] pa_o;
      logic [7:0] pa_oe;
      logic [7:0] pa_pe;
      logic [7:0] pa_pu;
      logic [7:0] pb_o;
      logic [7:0] pb_oe;
      logic [7:0] pb_pe;
      logic [7:0] pb_pu;
      logic [11:0] dac_l;
      logic [11:0] dac_r;
      logic main_irq;
      logic irq_req;
      logic nmi_req;
      logic [15:0] vec;
      logic sleep;
   } state_t;

   state_t q;
   state_t d;
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic wr;
   logic rd;
   logic [13:0] rd_ix;
   logic [7:0] rv;
   logic rmap;
   logic [16:0] dr;
   logic [32:0] adj;
   logic [4:0] pos;
   logic [15:0] cur;
   logic ext_ev;
   logic [7:0] pbo;
   logic [7:0] pbe;

   // reset release through two flops
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign wr = q.aw_got & q.w_got & ~q.bvalid;
   assign rd = ARVALID_I & q.arready;
   assign rd_ix = ARADDR_I[15:2];

   // register read mux
   always_comb begin
      rv = 8'h0;
      rmap = 1'b1;
      case (rd_ix)
         IX_TA_LO: rv = q.ta_rel[7:0];
         IX_TA_HI: rv = q.ta_rel[15:8];
         IX_TA_CTL: rv = {6'h0, q.ta_ctl};
         IX_TB_LO: rv = q.tb_rel[7:0];
         IX_TB_HI: rv = q.tb_rel[15:8];
         IX_TB_CTL: rv = {6'h0, q.tb_ctl};
         IX_TA_CLR, IX_TB_CLR, IX_DV_LO, IX_DV_HI: rv = 8'h0;
         IX_L_LO: rv = q.smp_l[7:0];
         IX_L_HI: rv = q.smp_l[15:8];
         IX_R_LO: rv = q.smp_r[7:0];
         IX_R_HI: rv = q.smp_r[15:8];
         IX_ISC: rv = {q.db_flag, q.ext_flag, 1'b0, q.isc};
         IX_SA: rv = {6'h0, q.sa_ctl};
         IX_OP0: rv = q.res[7:0];
         IX_OP1: rv = q.res[15:8];
         IX_OP2: rv = q.res[23:16];
         IX_OP3: rv = q.res[31:24];
         IX_MC_LO: rv = q.res[39:32];
         IX_MC_HI: rv = q.res[47:40];
         IX_PA_DAT: rv = (q.pa_dir & q.pa_dat) | (~q.pa_dir & q.pa_s2);
         IX_PA_DIR: rv = q.pa_dir;
         IX_PA_ATT: rv = q.pa_att;
         IX_PB_DAT: rv = (q.pb_dir & q.pb_dat) | (~q.pb_dir & q.pb_s2);
         IX_PB_DIR: rv = q.pb_dir;
         IX_PB_ATT: rv = q.pb_att;
         default: rmap = 1'b0;
      endcase
   end

   always_comb begin
      d = q;
      dr = 17'h0;
      adj = 33'h0;
      // axi write channel
      if (AWVALID_I & q.awready) begin
         d.aw_got = 1'b1;
         d.aw_ix = AWADDR_I[15:2];
      end
      if (WVALID_I & q.wready) begin
         d.w_got = 1'b1;
         d.w_b = WDATA_I[7:0];
         d.w_en = WSTRB_I[0];
      end
      if (q.bvalid & BREADY_I) begin
         d.bvalid = 1'b0;
      end
      // pin synchronisers
      d.pa_s1 = PA_I;
      d.pa_s2 = q.pa_s1;
      d.pb_s1 = PB_I;
      d.pb_s2 = q.pb_s1;
      d.b7_prev = q.pb_s2[PB_EXT];
      d.db_prev = DOORBELL_I;
      // timers count while running
      if (q.ta_ctl[CTL_RUN]) begin
         if (q.ta_cnt == TMR_TOP) begin
            d.ta_cnt = q.ta_rel;
         end else begin
            d.ta_cnt = q.ta_cnt + 16'h1;
         end
      end
      if (q.tb_ctl[CTL_RUN]) begin
         if (q.tb_cnt == TMR_TOP) begin
            d.tb_cnt = q.tb_rel;
         end else begin
            d.tb_cnt = q.tb_cnt + 16'h1;
         end
      end
      // arithmetic unit
      case (q.ar)
         AR_IDLE: begin
         end
         AR_MUL: begin
            if (q.mc[0]) begin
               d.res[31:0] = q.res[31:0]
                  + 32'({16'h0, q.opnd[15:0]} << q.ar_cnt);
            end
            d.mc = {1'b0, q.mc[15:1]};
            d.ar_cnt = q.ar_cnt + 6'h1;
            if (q.ar_cnt == MUL_CYC - 6'h1) begin
               d.ar = AR_IDLE;
            end
         end
         AR_DIV: begin
            dr = {q.rem[15:0], q.opnd[31]};
            d.opnd = {q.opnd[30:0], 1'b0};
            if (dr >= {1'b0, q.dv}) begin
               dr = dr - {1'b0, q.dv};
               d.opnd[0] = 1'b1;
            end
            d.rem = dr;
            d.ar_cnt = q.ar_cnt + 6'h1;
            if (q.ar_cnt == DIV_CYC - 6'h1) begin
               d.ar = AR_IDLE;
               d.res[31:0] = d.opnd;
               adj = {16'h0, dr} + {1'b0, d.opnd};
               if (d.opnd[0]) begin
                  d.res[47:32] = adj[16:1];
               end else begin
                  d.res[47:32] = dr[15:0];
               end
            end
         end
         default: d.ar = AR_IDLE;
      endcase
      // register writes
      if (wr) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OK;
         if (q.w_en) begin
            case (q.aw_ix)
               IX_TA_LO: d.ta_rel[7:0] = q.w_b;
               IX_TA_HI: begin
                  d.ta_rel[15:8] = q.w_b;
                  d.ta_cnt = {q.w_b, q.ta_rel[7:0]};
               end
               IX_TA_CTL: d.ta_ctl = q.w_b[1:0];
               IX_TA_CLR: d.ta_flag = 1'b0;
               IX_TB_LO: d.tb_rel[7:0] = q.w_b;
               IX_TB_HI: begin
                  d.tb_rel[15:8] = q.w_b;
                  d.tb_cnt = {q.w_b, q.tb_rel[7:0]};
               end
               IX_TB_CTL: d.tb_ctl = q.w_b[1:0];
               IX_TB_CLR: d.tb_flag = 1'b0;
               IX_L_LO: d.smp_l[7:0] = q.w_b;
               IX_L_HI: d.smp_l[15:8] = q.w_b;
               IX_R_LO: d.smp_r[7:0] = q.w_b;
               IX_R_HI: d.smp_r[15:8] = q.w_b;
               IX_ISC: begin
                  d.isc = q.w_b[4:0];
                  d.ext_flag = 1'b0;
                  d.sleep = q.w_b[ISC_SLEEP];
               end
               IX_SA: d.sa_ctl = q.w_b[1:0];
               IX_OP0: d.opnd[7:0] = q.w_b;
               IX_OP1: d.opnd[15:8] = q.w_b;
               IX_OP2: d.opnd[23:16] = q.w_b;
               IX_OP3: d.opnd[31:24] = q.w_b;
               IX_MC_LO: d.mc[7:0] = q.w_b;
               IX_MC_HI: begin
                  d.mc[15:8] = q.w_b;
                  d.res[31:0] = 32'h0;
                  d.ar_cnt = 6'h0;
                  d.ar = AR_MUL;
               end
               IX_DV_LO: d.dv[7:0] = q.w_b;
               IX_DV_HI: begin
                  d.dv[15:8] = q.w_b;
                  d.rem = 17'h0;
                  d.ar_cnt = 6'h0;
                  d.ar = AR_DIV;
               end
               IX_PA_DAT: d.pa_dat = q.w_b;
               IX_PA_DIR: d.pa_dir = q.w_b;
               IX_PA_ATT: d.pa_att = q.w_b;
               IX_PB_DAT: d.pb_dat = q.w_b;
               IX_PB_DIR: d.pb_dir = q.w_b;
               IX_PB_ATT: d.pb_att = q.w_b;
               default: d.bresp = RESP_ERR;
            endcase
         end
      end
      // axi read channel
      if (q.rvalid & RREADY_I) begin
         d.rvalid = 1'b0;
      end
      if (rd) begin
         d.rvalid = 1'b1;
         d.rdata = {24'h0, rv};
         d.rresp = rmap ? RESP_OK : RESP_ERR;
         if (rd_ix == IX_ISC) begin
            d.db_flag = 1'b0;
         end
      end
      d.awready = ~d.aw_got & ~d.bvalid;
      d.wready = ~d.w_got & ~d.bvalid;
      d.arready = ~d.rvalid;
      // event flags: set wins over clear
      if (q.ta_ctl[CTL_RUN] & (q.ta_cnt == TMR_TOP)) begin
         d.ta_flag = 1'b1;
      end
      if (q.tb_ctl[CTL_RUN] & (q.tb_cnt == TMR_TOP)) begin
         d.tb_flag = 1'b1;
      end
      if (DOORBELL_I & ~q.db_prev) begin
         d.db_flag = 1'b1;
      end
      ext_ev = q.isc[ISC_EXT_SEL] ? EXT_WRITE_DONE_I
         : (q.b7_prev & ~q.pb_s2[PB_EXT]);
      if (ext_ev) begin
         d.ext_flag = 1'b1;
      end
      // interrupt requests and vector
      d.nmi_req = NMI_I & d.isc[ISC_NMI_EN];
      d.irq_req = (d.ext_flag & d.isc[ISC_EXT_EN])
         | (d.ta_flag & d.ta_ctl[CTL_IE])
         | (d.tb_flag & d.tb_ctl[CTL_IE])
         | d.db_flag;
      if (d.nmi_req) begin
         d.vec = VEC_NMI;
      end else if (d.ext_flag & d.isc[ISC_EXT_EN]) begin
         d.vec = VEC_EXT;
      end else if (d.ta_flag & d.ta_ctl[CTL_IE]) begin
         d.vec = VEC_TA;
      end else if (d.tb_flag & d.tb_ctl[CTL_IE]) begin
         d.vec = VEC_TB;
      end else if (d.db_flag) begin
         d.vec = VEC_DB;
      end else begin
         d.vec = VEC_RST;
      end
      if (d.nmi_req | d.irq_req) begin
         d.sleep = 1'b0;
      end
      d.main_irq = d.isc[ISC_DB_OUT];
      d.dac_l = q.smp_l[15:4];
      d.dac_r = q.smp_r[15:4];
      // serial audio bit clock and frame counter
      if (q.sa_ctl[SA_EN]) begin
         if (q.sa_div == 3'(SA_HALF_CYC - 1)) begin
            d.sa_div = 3'h0;
            d.sa_bclk = ~q.sa_bclk;
            if (q.sa_bclk) begin
               d.sa_cnt = q.sa_cnt + 5'h1;
            end
         end else begin
            d.sa_div = q.sa_div + 3'h1;
         end
      end else begin
         d.sa_div = 3'h0;
         d.sa_bclk = 1'b0;
         d.sa_cnt = 5'h0;
      end
      pos = q.sa_cnt - {4'h0, q.sa_ctl[SA_FMT]};
      cur = pos[4] ? q.smp_r : q.smp_l;
      // pin drivers
      d.pa_o = q.pa_dir & q.pa_dat;
      d.pa_oe = q.pa_dir;
      d.pa_pe = ~q.pa_dir & q.pa_att;
      d.pa_pu = q.pa_dat;
      pbo = q.pb_dir & q.pb_dat;
      pbe = q.pb_dir;
      if (q.sa_ctl[SA_EN]) begin
         pbo[PB_BCLK] = q.sa_bclk;
         pbo[PB_SDAT] = cur[~pos[3:0]];
         pbo[PB_WSEL] = q.sa_cnt[4];
         pbe[PB_BCLK] = 1'b1;
         pbe[PB_SDAT] = 1'b1;
         pbe[PB_WSEL] = 1'b1;
      end
      d.pb_o = pbo;
      d.pb_oe = pbe;
      d.pb_pe = ~pbe & q.pb_att;
      d.pb_pu = q.pb_dat;
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.ar <= AR_IDLE;
         q.vec <= VEC_RST;
      end else begin
         q <= d;
      end
   end

   assign AWREADY_O = q.awready;
   assign WREADY_O = q.wready;
   assign BRESP_O = q.bresp;
   assign BVALID_O = q.bvalid;
   assign ARREADY_O = q.arready;
   assign RDATA_O = q.rdata;
   assign RRESP_O = q.rresp;
   assign RVALID_O = q.rvalid;
   assign MAIN_IRQ_O = q.main_irq;
   assign IRQ_REQ_O = q.irq_req;
   assign NMI_REQ_O = q.nmi_req;
   assign VECTOR_O = q.vec;
   assign SLEEP_O = q.sleep;
   assign DAC_L_O = q.dac_l;
   assign DAC_R_O = q.dac_r;
   assign PA_O = q.pa_o;
   assign PA_OE_O = q.pa_oe;
   assign PA_PULL_EN_O = q.pa_pe;
   assign PA_PULL_UP_O = q.pa_pu;
   assign PB_O = q.pb_o;
   assign PB_OE_O = q.pb_oe;
   assign PB_PULL_EN_O = q.pb_pe;
   assign PB_PULL_UP_O = q.pb_pu;

   a_reload_high_copy: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      (wr & q.w_en & (q.aw_ix == IX_TA_HI))
      |=> (q.ta_cnt == {$past(q.w_b), q.ta_rel[7:0]}))
      else $error("timer a counter not loaded from reload");
   a_timer_flag_set: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      (q.ta_ctl[CTL_RUN] & (q.ta_cnt == TMR_TOP)
         & ~(wr & q.w_en & (q.aw_ix == IX_TA_HI)))
      |=> (q.ta_flag && q.ta_cnt == $past(q.ta_rel)))
      else $error("timer a overflow did not flag and reload");
   a_timer_clear: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      (wr & q.w_en & (q.aw_ix == IX_TA_CLR)
         & ~(q.ta_ctl[CTL_RUN] & (q.ta_cnt == TMR_TOP)))
      |=> !q.ta_flag)
      else $error("timer a flag not cleared");
   a_dac_msbs: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      ##1 (DAC_L_O == $past(q.smp_l[15:4]))
         && (DAC_R_O == $past(q.smp_r[15:4])))
      else $error("converter word not sample bits 15 to 4");
   a_irq_masked: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      (!d.ta_ctl[CTL_IE] && !d.tb_ctl[CTL_IE]
         && !d.isc[ISC_EXT_EN] && !d.db_flag)
      |=> !IRQ_REQ_O)
      else $error("masked interrupt was requested");
   a_doorbell_out: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      (wr & q.w_en & (q.aw_ix == IX_ISC))
      |=> ##1 (MAIN_IRQ_O == $past(q.w_b[ISC_DB_OUT], 2)))
      else $error("main interrupt line not following bit 4");
   a_doorbell_rdclr: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      (rd && rd_ix == IX_ISC && !(DOORBELL_I && !q.db_prev))
      |=> !q.db_flag)
      else $error("doorbell flag not cleared by read");
   a_mul_length: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      (wr & q.w_en & (q.aw_ix == IX_MC_HI))
      |-> ##16 (q.ar == AR_MUL) ##1 (q.ar == AR_IDLE))
      else $error("multiply not 16 cycles");
   a_div_length: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      (wr & q.w_en & (q.aw_ix == IX_DV_HI))
      |-> ##32 (q.ar == AR_DIV) ##1 (q.ar == AR_IDLE))
      else $error("divide not 32 cycles");
   a_pin_drive: assert property (
      @(posedge CLK_I) disable iff (!rst_n)
      ##1 (PA_OE_O == $past(q.pa_dir))
         && (PA_PULL_EN_O == ($past(~q.pa_dir & q.pa_att))))
      else $error("port a drive or pull wrong");
endmodule : acp_top
`default_nettype wire
